// ---- design/debug_status_params.svh ----
`ifndef DEBUG_STATUS_PARAMS_SVH
`define DEBUG_STATUS_PARAMS_SVH

// register byte address
`define DEBUG_STATUS_ADDR      16'hFD00
// control register of own choosing: debug enable only
`define DEBUG_CTRL_ADDR        16'hFD04
// reset values
`define DEBUG_STATUS_RST_EXEC  32'h0000_0000
`define DEBUG_STATUS_RST_HALT  32'h0000_0002
// field positions
`define DS_ENABLE_BIT          0
`define DS_HALT_BIT            1
`define DS_HALT_MASK_BIT       2
`define DS_SUSPEND_OUT_STATE_IN_BIT         3
`define DS_SUSPEND_OUT_STATE_OUT_BIT        4
`define DS_PRIOR_SUSPEND_OUT_STATE_BIT      6
`define DS_POSTED_BIT          7
`define DS_ORIGIN_LSB          8
`define DS_ORIGIN_MSB          12
// event origin codes
`define ORIGIN_EXTERNAL        5'h00
`define ORIGIN_CORE_REG        5'h01
`define ORIGIN_SOFTWARE        5'h02
`define ORIGIN_TRIGGER_BASE    5'h10
// axi responses
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// ---- design/debug_status_pkg.sv ----
package debug_status_pkg;
   // bus write phase tracking
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } wr_state_t;
endpackage

// ---- design/core_debug_status.sv ----
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "debug_status_params.svh"
// Notes on behaviour
// - reset zero, or halt bit when boot-halt
// - five-bit origin of last debug event
// - posted flag bit 7, hardware set, writable
// - bit 4 drives suspend out, sw/hw
// - bit 3 read-only mirror of suspend in
// - no halt without boot strap, suspend in, event, write
// - halt mask bit gates write, reads zero
// - halt reads 00 running, 01 halted
// - write 10 clears, 11 sets if enabled
// - bit 0 read-only debug enable status
// - suspend in halts while debug enabled
// - origin always updates, suspend not when posted
module core_debug_status
   import debug_status_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // boot strap: 1 boots into halt
   input  wire logic        boot_halt,
   // axi4-lite write address
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // debug event from the event logic
   input  wire logic        dbg_event,
   input  wire logic [4:0]  dbg_event_origin,
   input  wire logic        dbg_event_suspend,
   input  wire logic        dbg_event_halt,
   input  wire logic        dbg_event_posted,
   // suspend signals
   input  wire logic        suspend_in,
   output logic             suspend_out,
   // cpu halt status
   output logic             cpu_halted
);

   // register state; everything software or an event can change
   // lives here, the status word is assembled from it
   logic       enable_q;          // debug controller enabled
   logic       strap_done_q;      // first edge after reset release seen
   logic       halt_q;            // actual halt bit
   logic       suspend_out_state_out_q;        // suspend-out state
   logic       prior_suspend_out_state_q;      // previous suspend-out
   logic       posted_q;          // posted event flag
   logic [4:0] origin_q;          // last event origin
   // bus state; address and data are held apart so that either
   // channel may arrive first
   wr_state_t  wr_state_q;        // write phase
   logic       aw_held_q;         // write address captured
   logic       w_held_q;          // write data captured
   logic [15:0] awaddr_q;         // captured write address
   logic [31:0] wdata_q;          // captured write data
   logic [3:0]  wstrb_q;          // captured byte strobes
   logic        rvalid_q;         // read data pending
   logic [31:0] rdata_q;          // read data register
   logic [1:0]  rresp_q;          // read response
   logic [1:0]  bresp_q;          // write response

   // decoded write strobes; valid only in the single commit cycle
   // of a write
   logic        wr_fire;          // write commits this cycle
   logic        wr_status;        // write hits status register
   logic        wr_ctrl;          // write hits control register
   logic [31:0] status_view;      // assembled status word

   // address match helper; compares word addresses, so the two low
   // byte bits never select a different register
   function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] base);
      addr_hit = (a[15:2] == base[15:2]);
   endfunction

   // write channel handshakes; each channel is refused once its half
   // of the write is held, so address and data may come in any order
   assign s_axi_awready = (wr_state_q == WR_IDLE) && !aw_held_q;
   assign s_axi_wready  = (wr_state_q == WR_IDLE) && !w_held_q;
   assign s_axi_bvalid  = (wr_state_q == WR_RESP);
   assign s_axi_bresp   = bresp_q;
   // read channel handshakes; one read at a time, a new address
   // waits until the previous data has been taken
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // outputs driven from state; suspend in halts the cpu only while
   // debug is enabled, and the halt drops again as soon as it falls
   assign suspend_out = suspend_out_state_out_q;
   assign cpu_halted  = halt_q || (enable_q && suspend_in);

   // write commit once both address and data are held; the register
   // update and the move to the response phase share this one cycle
   assign wr_fire   = (wr_state_q == WR_IDLE) && aw_held_q && w_held_q;
   assign wr_status = wr_fire && addr_hit(awaddr_q, `DEBUG_STATUS_ADDR);
   assign wr_ctrl   = wr_fire && addr_hit(awaddr_q, `DEBUG_CTRL_ADDR);

   // assemble status word; reserved bits and mask bit read zero
   // the suspend-in bit is a live view of the pin, not a stored copy
   always_comb begin
      status_view = 32'h0000_0000;
      status_view[`DS_ENABLE_BIT]   = enable_q;
      status_view[`DS_HALT_BIT]     = halt_q;
      status_view[`DS_HALT_MASK_BIT] = 1'b0;
      status_view[`DS_SUSPEND_OUT_STATE_IN_BIT]  = suspend_in;
      status_view[`DS_SUSPEND_OUT_STATE_OUT_BIT] = suspend_out_state_out_q;
      status_view[`DS_PRIOR_SUSPEND_OUT_STATE_BIT] = prior_suspend_out_state_q;
      status_view[`DS_POSTED_BIT]   = posted_q;
      status_view[`DS_ORIGIN_MSB:`DS_ORIGIN_LSB] = origin_q;
   end

   // capture write address
   // the slot stays full until the commit cycle frees it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 16'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         // address taken; kept until the write commits
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   // capture write data
   // data and strobes are held together until the commit cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         // data taken; kept until the write commits
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   // write response phase; unmapped address answers slverr
   // no new write is taken until the response has been accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_q <= WR_IDLE;
         bresp_q    <= `RESP_OKAY;
      end else begin
         unique case (wr_state_q)
            WR_IDLE: begin
               if (wr_fire) begin
                  // commit: answer on the next cycle
                  wr_state_q <= WR_RESP;
                  bresp_q    <= (wr_status || wr_ctrl) ? `RESP_OKAY : `RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  // response accepted, channels open again
                  wr_state_q <= WR_IDLE;
               end
            end
         endcase
      end
   end

   // read path; data registered one cycle after address taken
   // the word is frozen at that edge and stands until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         if (addr_hit(s_axi_araddr, `DEBUG_STATUS_ADDR)) begin
            // status register
            rdata_q <= status_view;
            rresp_q <= `RESP_OKAY;
         end else if (addr_hit(s_axi_araddr, `DEBUG_CTRL_ADDR)) begin
            // control register, enable bit only
            rdata_q <= {31'h0000_0000, enable_q};
            rresp_q <= `RESP_OKAY;
         end else begin
            // unmapped: zero data with an error response
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_SLVERR;
         end
      end else if (rvalid_q && s_axi_rready) begin
         // data accepted, ready for the next address
         rvalid_q <= 1'b0;
      end
   end

   // mark the first edge after reset release; the halt bit loads the
   // boot strap on that edge only, so a strap that moves later is ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // strap not yet applied
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         // strap applied now, never again until the next reset
         strap_done_q <= 1'b1;
      end
   end

   // debug enable, software controlled through the control register
   // it stays off after reset, so a boot halt is left by a clear write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q <= 1'b0;
      end else if (wr_ctrl && wstrb_q[0]) begin
         // only the lowest byte lane carries the enable bit
         enable_q <= wdata_q[0];
      end
   end

   // halt bit: strap, debug event, masked software write
   // a masked software write beats an event halt in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         halt_q <= 1'b0;
      end else if (!strap_done_q) begin
         halt_q <= boot_halt;
      end else if (wr_status && wstrb_q[0] && wdata_q[`DS_HALT_MASK_BIT]) begin
         // without the mask bit a write leaves the halt bit alone
         // mask set: 10 clears, 11 sets only while enabled          
         if (!wdata_q[`DS_HALT_BIT]) begin
            halt_q <= 1'b0;
         end else if (enable_q) begin
            halt_q <= 1'b1;
         end
      end else if (dbg_event && dbg_event_halt) begin
         // a halting event sets the bit; only software clears it
         halt_q <= 1'b1;
      end
   end

   // suspend-out and its previous state
   // the previous state moves only on a hardware update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         suspend_out_state_out_q   <= 1'b0;
         prior_suspend_out_state_q <= 1'b0;
      end else if (dbg_event && !dbg_event_posted) begin
         // event update; beats a software write in the same cycle
         prior_suspend_out_state_q <= suspend_out_state_out_q;
         suspend_out_state_out_q   <= dbg_event_suspend;
      end else if (wr_status && wstrb_q[0]) begin
         suspend_out_state_out_q   <= wdata_q[`DS_SUSPEND_OUT_STATE_OUT_BIT];
      end
   end

   // posted flag: hardware set wins over software write
   // a status write also writes this bit, so write back what was read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         posted_q <= 1'b0;
      end else if (dbg_event && dbg_event_posted) begin
         // posted event sets the flag, suspend bits untouched
         posted_q <= 1'b1;
      end else if (wr_status && wstrb_q[0]) begin
         posted_q <= wdata_q[`DS_POSTED_BIT];
      end
   end

   // event origin, updated on every event
   // software cannot write it; reserved codes are stored as given
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         origin_q <= `ORIGIN_EXTERNAL;
      end else if (dbg_event) begin
         // posted or not, the origin follows the event
         origin_q <= dbg_event_origin;
      end
   end

endmodule

// ---- test/core_debug_status_props.sv ----
`timescale 1ns/100ps
module core_debug_status_props (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // debug event and suspend
   input wire logic        dbg_event,
   input wire logic        dbg_event_suspend,
   input wire logic        dbg_event_posted,
   input wire logic        suspend_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write channels taken together
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // response follows within two edges
   sequence wr_answer;
      ##[1:2] s_axi_bvalid;
   endsequence
   a_write_answer: assert property (wr_taken |-> wr_answer)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while busy");
   a_resv_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:13] == 19'h0 && !s_axi_rdata[5] && !s_axi_rdata[2])
      else $error("reserved bits set");
   a_suspend_out_state_event: assert property (
      dbg_event && !dbg_event_posted |=> suspend_out == $past(dbg_event_suspend))
      else $error("suspend out not updated");
   a_suspend_out_state_post: assert property (
      dbg_event && dbg_event_posted |=> $stable(suspend_out) || $rose(s_axi_bvalid))
      else $error("suspend out changed");
endmodule
bind core_debug_status core_debug_status_props i_props (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .dbg_event, .dbg_event_suspend, .dbg_event_posted, .suspend_out);

// ---- test/neighbour_suspend.sv ----
`timescale 1ns/100ps
// neighbour core: raises its suspend line lag plus one cycles after a hold request
module neighbour_suspend (
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // hold request and answer delay
   input wire logic       hold_req,
   input wire logic [2:0] lag,
   // suspend line to the core
   output logic           suspend_in
);
   logic [7:0] pipe_q; // request history
   // delay line, so both prompt and slow answers occur
   always_ff @(posedge aclk) begin
      if (!aresetn) pipe_q <= 8'h00;
      else pipe_q <= {pipe_q[6:0], hold_req};
   end
   assign suspend_in = pipe_q[lag];
endmodule

// ---- test/tb_core_debug_status.sv ----
`timescale 1ns/100ps
`include "debug_status_params.svh"
module tb_core_debug_status;
   logic        aclk = 1'h0, aresetn = 1'h0, boot_halt = 1'h0, hold_req = 1'h0;
   logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, code;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, suspend_in, suspend_out;
   logic        dbg_event = 1'h0, dbg_event_suspend = 1'h0, dbg_event_halt = 1'h0;
   logic        dbg_event_posted = 1'h0, cpu_halted;
   logic [4:0]  dbg_event_origin = 5'h00, org;
   logic [2:0]  lag = 3'h0;
   logic [33:0] rq[$]; // expected response and read data
   logic [1:0]  bq[$]; // expected write responses
   int          bad_count = 0, checked = 0;
   always #5 aclk = ~aclk;
   core_debug_status i_core_debug_status (.aclk, .aresetn, .boot_halt, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .dbg_event, .dbg_event_origin, .dbg_event_suspend, .dbg_event_halt,
      .dbg_event_posted, .suspend_in, .suspend_out, .cpu_halted);
   neighbour_suspend i_neighbour_suspend (.aclk, .aresetn, .hold_req, .lag, .suspend_in);
   // compare one result, counting mismatches
   task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // one bus transfer; results are judged by the monitor below
   task automatic xfer(input logic wn, input logic [15:0] ad, input logic [31:0] d,
                       input logic [1:0] e);
      logic ta, tw, tr, done;
      @(posedge aclk);
      if (wn) begin
         bq.push_back(e);
         s_axi_awaddr  <= ad;
         s_axi_wdata   <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid  <= 1'h1;
         s_axi_bready  <= 1'h1;
      end else begin
         rq.push_back({e, d});
         s_axi_araddr  <= ad;
         s_axi_arvalid <= 1'h1;
         s_axi_rready  <= 1'h1;
      end
      done = 1'h0;
      while (!done) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tr = s_axi_arvalid && s_axi_arready;
         done = s_axi_bvalid || s_axi_rvalid;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tr) s_axi_arvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
   endtask
   // status read against the model, then the halt and suspend-out pins
   task automatic chk();
      xfer(1'h0, `DEBUG_STATUS_ADDR, st, `RESP_OKAY);
      @(negedge aclk);
      cmp("halted", {33'h0, st[1] | (st[0] & st[3])}, {33'h0, cpu_halted});
      cmp("suspend_out", {33'h0, st[4]}, {33'h0, suspend_out});
   endtask
   // one-cycle debug event; qualifiers flip afterwards
   task automatic ev(input logic [4:0] o, input logic s, input logic h, input logic p);
      @(posedge aclk);
      {dbg_event, dbg_event_origin, dbg_event_suspend} <= {1'h1, o, s};
      {dbg_event_halt, dbg_event_posted} <= {h, p};
      @(posedge aclk);
      {dbg_event, dbg_event_origin, dbg_event_suspend} <= {1'h0, ~o, ~s};
      {dbg_event_halt, dbg_event_posted} <= {~h, ~p};
   endtask
   // monitor: oldest note against each result
   always @(negedge aclk) begin
      if (s_axi_rvalid && s_axi_rready)
         cmp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
   end
   initial begin
      void'($urandom(30));
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      st = 32'h0;
      chk();
      xfer(1'h0, 16'hFD08, 32'h0, `RESP_SLVERR);
      xfer(1'h1, 16'hFD08, 32'h1, `RESP_SLVERR);
      xfer(1'h1, `DEBUG_STATUS_ADDR, 32'h6, `RESP_OKAY);
      chk();
      xfer(1'h1, `DEBUG_CTRL_ADDR, 32'h1, `RESP_OKAY);
      st = 32'h1;
      xfer(1'h0, `DEBUG_CTRL_ADDR, 32'h1, `RESP_OKAY);
      for (int c = 0; c < 8; c++) begin
         code = 2'(16'b01_10_00_11_10_00_01_11 >> (2 * c));
         xfer(1'h1, `DEBUG_STATUS_ADDR, {24'hFFFFFF, 5'h04, code, 1'h0}, `RESP_OKAY);
         if (code == 2'h2) st[1] = 1'h0;
         else if (code == 2'h3) st[1] = 1'h1;
         chk();
      end
      $display("halt field test done");
      for (int k = 0; k < 6; k++) begin
         org = (k < 3) ? 5'(k) : 5'h10 + 5'($urandom % 8);
         ev(org, ~st[4], k == 5, k == 4);
         st[12:8] = org;
         if (k == 4) st[7] = 1'h1;
         else st[6:4] = {st[4], 1'h0, ~st[4]};
         if (k == 5) st[1] = 1'h1;
         chk();
      end
      xfer(1'h1, `DEBUG_STATUS_ADDR, {27'h0, ~st[4], 4'h4}, `RESP_OKAY);
      st[7] = 1'h0;
      st[4] = ~st[4];
      st[1] = 1'h0;
      chk();
      $display("event test done");
      @(posedge aclk);
      hold_req <= 1'h1;
      lag <= 3'($urandom % 5);
      repeat (8) @(posedge aclk);
      st[3] = 1'h1;
      chk();
      xfer(1'h1, `DEBUG_CTRL_ADDR, 32'h0, `RESP_OKAY);
      st[0] = 1'h0;
      chk();
      @(posedge aclk);
      hold_req <= 1'h0;
      repeat (8) @(posedge aclk);
      st[3] = 1'h0;
      chk();
      $display("suspend test done");
      @(posedge aclk);
      boot_halt <= 1'h1;
      aresetn <= 1'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      st = 32'h2;
      chk();
      $display("boot halt test done");
      wrap_up();
   end
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
   // verdict
   task automatic wrap_up();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
endmodule
